// [shared/ssx_pkg.sv]
// ------------------------------------------------------------
// Constants for the skip and subtract executor
// ------------------------------------------------------------
package ssx_pkg;

   // APB byte addresses of the control registers
   localparam logic [11:0] ADDR_INSTR = 12'h000;
   localparam logic [11:0] ADDR_ACC = 12'h004;
   localparam logic [11:0] ADDR_FLAGS = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_MEM_BASE = 12'h040;

   // Instruction register fields
   localparam int INSTR_OP_LSB = 0;
   localparam int INSTR_BIT_LSB = 4;
   localparam int INSTR_ADDR_LSB = 8;

   // Flag bit positions in the flags register
   localparam int FLG_OVERFLOW = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_AUX_CARRY = 2;
   localparam int FLG_C = 3;
   localparam int FLG_SIGNED_CMP = 4;
   localparam int FLG_CMP_ZERO = 5;
   localparam int FLAGS_W = 6;

   // Status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_SKIP = 1;
   localparam int STAT_CYC_LSB = 2;
   localparam int STAT_ILLEGAL = 4;

   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [7:0] MEM_RST = 8'h00;

   // Instruction lengths in instruction cycles
   localparam logic [1:0] CYC_NORMAL = 2'h2;
   localparam logic [1:0] CYC_SKIP = 2'h3;

   typedef enum logic [2:0] {
      OP_INC_MEM_SKIP_ZERO = 3'h0,
      OP_INC_TO_ACC_SKIP_ZERO = 3'h1,
      OP_SKIP_BIT_NONZERO = 3'h2,
      OP_SKIP_IF_NONZERO = 3'h3,
      OP_SUB_MEM_FROM_ACC = 3'h4,
      OP_SUB_MEM_RESULT_TO_MEM = 3'h5,
      OP_NIBBLE_EXCHANGE = 3'h6
   } ssx_op_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_EXEC = 4'h2,
      ST_FETCH = 4'h4,
      ST_DUMMY = 4'h8
   } ssx_state_t;

endpackage : ssx_pkg

// [shared/ssx_alu_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Operands and results between sequencer and datapath
// ------------------------------------------------------------
interface ssx_alu_if;
   logic [2:0] op;
   logic [7:0] acc;
   logic [7:0] mem;
   logic [2:0] bit_sel;
   logic [7:0] result;
   logic wr_mem;
   logic wr_acc;
   logic wr_flags;
   logic skip;
   logic illegal;
   logic [5:0] flags;

   modport core (output op, acc, mem, bit_sel,
                 input result, wr_mem, wr_acc, wr_flags, skip, illegal, flags);
   modport alu (input op, acc, mem, bit_sel,
                output result, wr_mem, wr_acc, wr_flags, skip, illegal, flags);
endinterface : ssx_alu_if
`default_nettype wire

// [verilog/ssx_dmem.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Flip-flop data memory, one write port, two read ports
// ------------------------------------------------------------
module ssx_dmem #(
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_addr_a,
   output logic [7:0] rd_data_a,
   input wire logic [AW-1:0] rd_addr_b,
   output logic [7:0] rd_data_b
);
   logic [7:0] mem_reg [DEPTH];

   // One storage byte per entry
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_byte
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_reg[gi] <= ssx_pkg::MEM_RST;
            end else if (wr_en && (wr_addr == AW'(gi))) begin
               mem_reg[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // Combinational reads so an instruction finishes in one execute cycle
   assign rd_data_a = mem_reg[rd_addr_a];
   assign rd_data_b = mem_reg[rd_addr_b];
endmodule : ssx_dmem
`default_nettype wire

// [verilog/ssx_alu.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Datapath: increment, bit test, subtract, nibble exchange
// ------------------------------------------------------------
module ssx_alu (
   ssx_alu_if.alu a
);
   logic [8:0] diff;
   logic [4:0] ndiff;
   logic ovf;

   // Borrow-extended subtraction; bit 8 is the borrow out
   assign diff = {1'b0, a.acc} - {1'b0, a.mem};
   assign ndiff = {1'b0, a.acc[3:0]} - {1'b0, a.mem[3:0]};
   assign ovf = (a.acc[7] != a.mem[7]) && (diff[7] != a.acc[7]);

   // Result, write enables and skip decision per opcode
   always_comb begin
      a.result = a.mem;
      a.wr_mem = 1'b0;
      a.wr_acc = 1'b0;
      a.wr_flags = 1'b0;
      a.skip = 1'b0;
      a.illegal = 1'b0;
      a.flags = '0;
      case (a.op)
         ssx_pkg::OP_INC_MEM_SKIP_ZERO: begin
            a.result = a.mem + 8'h01;
            a.wr_mem = 1'b1;
            a.skip = (a.result == 8'h00);
         end
         ssx_pkg::OP_INC_TO_ACC_SKIP_ZERO: begin
            a.result = a.mem + 8'h01;
            a.wr_acc = 1'b1;
            a.skip = (a.result == 8'h00);
         end
         ssx_pkg::OP_SKIP_BIT_NONZERO: begin
            a.skip = a.mem[a.bit_sel];
         end
         ssx_pkg::OP_SKIP_IF_NONZERO: begin
            a.wr_mem = 1'b1;
            a.skip = (a.mem != 8'h00);
         end
         ssx_pkg::OP_SUB_MEM_FROM_ACC,
         ssx_pkg::OP_SUB_MEM_RESULT_TO_MEM: begin
            a.result = diff[7:0];
            a.wr_acc = (a.op == ssx_pkg::OP_SUB_MEM_FROM_ACC);
            a.wr_mem = (a.op == ssx_pkg::OP_SUB_MEM_RESULT_TO_MEM);
            a.wr_flags = 1'b1;
            a.flags[ssx_pkg::FLG_OVERFLOW] = ovf;
            a.flags[ssx_pkg::FLG_Z] = (diff[7:0] == 8'h00);
            a.flags[ssx_pkg::FLG_AUX_CARRY] = ~ndiff[4];
            a.flags[ssx_pkg::FLG_C] = ~diff[8];
            a.flags[ssx_pkg::FLG_SIGNED_CMP] = ~(diff[7] ^ ovf);
            a.flags[ssx_pkg::FLG_CMP_ZERO] = (diff[7:0] == 8'h00);
         end
         ssx_pkg::OP_NIBBLE_EXCHANGE: begin
            a.result = {a.mem[3:0], a.mem[7:4]};
            a.wr_mem = 1'b1;
         end
         default: begin
            a.illegal = 1'b1;
         end
      endcase
   end
endmodule : ssx_alu
`default_nettype wire

// [verilog/ssx_skip_sub_exec.sv]
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module ssx_skip_sub_exec #(
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic exec_busy,
   output logic skip_taken
);
   // ------------------------------------------------------------
   // State and registers
   // ------------------------------------------------------------
   ssx_pkg::ssx_state_t state_reg, state_next;
   logic [2:0] op_reg;
   logic [2:0] bit_reg;
   logic [7:0] maddr_reg;
   logic [7:0] acc_reg;
   logic [5:0] flags_reg;
   logic skip_reg;
   logic illegal_reg;
   logic [1:0] cyc_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic busy_reg;

   ssx_alu_if alu_bus ();

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   localparam logic [11:0] MEM_END = ssx_pkg::ADDR_MEM_BASE + 12'(4 * DEPTH);

   wire setup = psel && !penable;
   wire access_edge = psel && penable && pready_reg;
   wire busy = (state_reg != ssx_pkg::ST_IDLE);
   wire hit_instr = (paddr == ssx_pkg::ADDR_INSTR);
   wire hit_acc = (paddr == ssx_pkg::ADDR_ACC);
   wire hit_flags = (paddr == ssx_pkg::ADDR_FLAGS);
   wire hit_status = (paddr == ssx_pkg::ADDR_STATUS);
   wire hit_mem = (paddr >= ssx_pkg::ADDR_MEM_BASE) && (paddr < MEM_END)
                  && (paddr[1:0] == 2'h0);
   wire mapped = hit_instr || hit_acc || hit_flags || hit_status || hit_mem;
   // Writes while an instruction runs are refused so operands stay stable
   wire err_next = !mapped || (pwrite && (busy || hit_status));
   wire wr_ok = access_edge && pwrite && !pslverr_reg;
   wire [AW-1:0] bus_idx = paddr[AW+1:2];

   // ------------------------------------------------------------
   // Data memory and datapath
   // ------------------------------------------------------------
   wire [AW-1:0] exec_idx = maddr_reg[AW-1:0];
   wire [7:0] mem_rd_x;
   wire [7:0] mem_rd_bus;
   wire in_exec = (state_reg == ssx_pkg::ST_EXEC);
   wire exec_wr = in_exec && alu_bus.wr_mem;
   wire mem_we = exec_wr || (wr_ok && hit_mem);
   wire [AW-1:0] mem_waddr = exec_wr ? exec_idx : bus_idx;
   wire [7:0] mem_wdata = exec_wr ? alu_bus.result : pwdata[7:0];
   wire bit_val = mem_rd_x[bit_reg];

   ssx_dmem #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_dmem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr_a(exec_idx),
      .rd_data_a(mem_rd_x),
      .rd_addr_b(bus_idx),
      .rd_data_b(mem_rd_bus)
   );

   // Operands for the datapath
   assign alu_bus.op = op_reg;
   assign alu_bus.acc = acc_reg;
   assign alu_bus.mem = mem_rd_x;
   assign alu_bus.bit_sel = bit_reg;

   ssx_alu u_alu (
      .a(alu_bus.alu)
   );

   // ------------------------------------------------------------
   // Read data selection
   // ------------------------------------------------------------
   wire [31:0] status_word = {27'h0, illegal_reg, cyc_reg, skip_reg, busy};
   wire [31:0] instr_word = {16'h0, maddr_reg, 1'b0, bit_reg, 1'b0, op_reg};
   wire [31:0] rd_mux = hit_instr ? instr_word :
                        hit_acc ? {24'h0, acc_reg} :
                        hit_flags ? {26'h0, flags_reg} :
                        hit_status ? status_word :
                        hit_mem ? {24'h0, mem_rd_bus} : 32'h0;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Execute, then fetch, then a dummy slot only when skipping
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ssx_pkg::ST_IDLE: begin
            if (wr_ok && hit_instr) begin
               state_next = ssx_pkg::ST_EXEC;
            end
         end
         ssx_pkg::ST_EXEC: begin
            state_next = ssx_pkg::ST_FETCH;
         end
         ssx_pkg::ST_FETCH: begin
            state_next = skip_reg ? ssx_pkg::ST_DUMMY : ssx_pkg::ST_IDLE;
         end
         ssx_pkg::ST_DUMMY: begin
            state_next = ssx_pkg::ST_IDLE;
         end
         default: begin
            state_next = ssx_pkg::ST_IDLE;
         end
      endcase
   end

   // State and busy indication
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ssx_pkg::ST_IDLE;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy_reg <= (state_next != ssx_pkg::ST_IDLE);
      end
   end

   // Instruction capture from the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_reg <= 3'h0;
         bit_reg <= 3'h0;
         maddr_reg <= 8'h00;
      end else if (wr_ok && hit_instr) begin
         op_reg <= pwdata[ssx_pkg::INSTR_OP_LSB +: 3];
         bit_reg <= pwdata[ssx_pkg::INSTR_BIT_LSB +: 3];
         maddr_reg <= pwdata[ssx_pkg::INSTR_ADDR_LSB +: 8];
      end
   end

   // Accumulator: the bus loads it only while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= ssx_pkg::ACC_RST;
      end else if (in_exec && alu_bus.wr_acc) begin
         acc_reg <= alu_bus.result;
      end else if (wr_ok && hit_acc) begin
         acc_reg <= pwdata[7:0];
      end
   end

   // Flags change only on subtracts; skips and exchange leave them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= ssx_pkg::FLAGS_RST;
      end else if (in_exec && alu_bus.wr_flags) begin
         flags_reg <= alu_bus.flags;
      end else if (wr_ok && hit_flags) begin
         flags_reg <= pwdata[5:0];
      end
   end

   // Outcome of the last instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_reg <= 1'b0;
         illegal_reg <= 1'b0;
         cyc_reg <= 2'h0;
      end else if (in_exec) begin
         skip_reg <= alu_bus.skip;
         illegal_reg <= alu_bus.illegal;
         cyc_reg <= alu_bus.skip ? ssx_pkg::CYC_SKIP : ssx_pkg::CYC_NORMAL;
      end
   end

   // ------------------------------------------------------------
   // APB response, registered for clean outputs
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup && err_next;
         if (setup) begin
            prdata_reg <= (pwrite || err_next) ? 32'h0 : rd_mux;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign exec_busy = busy_reg;
   assign skip_taken = skip_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire ex_inc_mem = in_exec && (op_reg == ssx_pkg::OP_INC_MEM_SKIP_ZERO);
   wire ex_inc_acc = in_exec && (op_reg == ssx_pkg::OP_INC_TO_ACC_SKIP_ZERO);
   wire ex_bit = in_exec && (op_reg == ssx_pkg::OP_SKIP_BIT_NONZERO);
   wire ex_nz = in_exec && (op_reg == ssx_pkg::OP_SKIP_IF_NONZERO);
   wire ex_sub_a = in_exec && (op_reg == ssx_pkg::OP_SUB_MEM_FROM_ACC);
   wire ex_sub_m = in_exec && (op_reg == ssx_pkg::OP_SUB_MEM_RESULT_TO_MEM);
   wire ex_swap = in_exec && (op_reg == ssx_pkg::OP_NIBBLE_EXCHANGE);

   a_inc_mem_wb: assert property (ex_inc_mem |=>
      (mem_rd_x == 8'($past(mem_rd_x) + 8'h01)) && (skip_reg == (mem_rd_x == 8'h00)))
      else $error("increment-skip write back or skip wrong");

   a_inc_wrap: assert property ((ex_inc_mem || ex_inc_acc) && (mem_rd_x == 8'hFF) |=>
      skip_reg && (cyc_reg == 2'h3))
      else $error("all-ones increment did not wrap and skip");

   a_inc_acc: assert property (ex_inc_acc |=>
      (acc_reg == 8'($past(mem_rd_x) + 8'h01)) && $stable(mem_rd_x)
      && (skip_reg == (acc_reg == 8'h00)))
      else $error("increment to accumulator wrong");

   a_skip_three: assert property (in_exec && alu_bus.skip |=>
      (state_reg == ssx_pkg::ST_FETCH) ##1 (state_reg == ssx_pkg::ST_DUMMY)
      ##1 (state_reg == ssx_pkg::ST_IDLE))
      else $error("skip did not take three cycles");

   a_noskip_two: assert property (in_exec && !alu_bus.skip |=>
      (state_reg == ssx_pkg::ST_FETCH) ##1 (state_reg == ssx_pkg::ST_IDLE))
      else $error("non-skipping instruction not two cycles");

   a_bit_skip: assert property (ex_bit |=> skip_reg == $past(bit_val))
      else $error("bit test skip decision wrong");

   a_nz_keep: assert property (ex_nz |=> $stable(mem_rd_x)
      && (skip_reg == ($past(mem_rd_x) != 8'h00)))
      else $error("nonzero test altered byte or skipped wrongly");

   a_sub_acc: assert property (ex_sub_a |=>
      (acc_reg == 8'($past(acc_reg) - $past(mem_rd_x))) && $stable(mem_rd_x))
      else $error("subtract to accumulator wrong");

   a_sub_mem: assert property (ex_sub_m |=>
      (mem_rd_x == 8'($past(acc_reg) - $past(mem_rd_x))) && $stable(acc_reg))
      else $error("subtract to memory wrong");

   a_sub_carry: assert property (ex_sub_a || ex_sub_m |=>
      flags_reg[ssx_pkg::FLG_C] == ($past(acc_reg) >= $past(mem_rd_x)))
      else $error("carry after subtract wrong");

   a_skip_flags: assert property (ex_inc_mem || ex_inc_acc || ex_bit || ex_nz |=>
      $stable(flags_reg))
      else $error("skip instruction changed flags");

   a_swap_nib: assert property (ex_swap |=>
      (mem_rd_x == {$past(mem_rd_x[3:0]), $past(mem_rd_x[7:4])}) && $stable(flags_reg))
      else $error("nibble exchange wrong");

   c_skip_dummy: cover property (in_exec && alu_bus.skip ##2 state_reg == ssx_pkg::ST_DUMMY);
   c_inc_wrap: cover property (ex_inc_mem && mem_rd_x == 8'hFF);
   c_sub_neg: cover property (ex_sub_a && acc_reg < mem_rd_x);
   c_refused: cover property (access_edge && pwrite && pslverr_reg && busy);

endmodule : ssx_skip_sub_exec
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic exec_busy;
   logic skip_taken;
   int num_errors;
   int cmp_count;
   logic [31:0] seed;
   int mem_m [16];
   int acc_m;
   int flags_m;

   ssx_skip_sub_exec #(.DEPTH(16)) DUT (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .exec_busy(exec_busy),
      .skip_taken(skip_taken)
   );

   // ------------------------------------------------------------
   // Clock, compare and closing helpers
   // ------------------------------------------------------------
   always #20 pclk = ~pclk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   // ------------------------------------------------------------
   // APB master: one idle cycle before each setup, so no double drive
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         close_out();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp);
   endtask : rd_chk

   task automatic wr(input logic [11:0] a, input int d, input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      chk({31'h0, err}, {31'h0, exp_err});
   endtask : wr

   // ------------------------------------------------------------
   // Run one instruction on model and design, then compare status, accumulator, flags and the addressed byte
   // ------------------------------------------------------------
   task automatic run(input int op, input int b, input int a);
      int m;
      int r;
      int sk;
      int n;
      int sa;
      int sm;
      m = mem_m[a];
      sk = 0;
      sa = (acc_m > 127) ? acc_m - 256 : acc_m;
      sm = (m > 127) ? m - 256 : m;
      r = (acc_m - m) & 255;
      case (op)
         0: begin
            mem_m[a] = (m + 1) % 256;
            sk = (mem_m[a] == 0);
         end
         1: begin
            acc_m = (m + 1) % 256;
            sk = (acc_m == 0);
         end
         2: sk = (m >> b) & 1;
         3: sk = (m != 0);
         4, 5: begin
            flags_m = ((sa - sm > 127 || sa - sm < -128) ? 1 : 0) + ((r == 0) ? 2 : 0)
                    + ((acc_m % 16 >= m % 16) ? 4 : 0) + ((acc_m >= m) ? 8 : 0)
                    + ((sa >= sm) ? 16 : 0) + ((r == 0) ? 32 : 0);
            if (op == 4) acc_m = r;
            else mem_m[a] = r;
         end
         6: mem_m[a] = (m % 16) * 16 + m / 16;
         default: ;
      endcase
      wr(ssx_pkg::ADDR_INSTR, (a << 8) + (b << 4) + op, 1'b0);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (exec_busy === 1'b1 && n < 10);
      // A hung sequencer ends the run rather than piling up later mismatches
      if (exec_busy === 1'b1) begin
         num_errors++;
         close_out();
      end
      chk(n - 1, 2 + sk);
      chk({31'h0, skip_taken}, sk);
      rd_chk(ssx_pkg::ADDR_STATUS, ((op == 7) ? 16 : 0) + (2 + sk) * 4 + sk * 2);
      rd_chk(ssx_pkg::ADDR_ACC, acc_m);
      rd_chk(ssx_pkg::ADDR_FLAGS, flags_m);
      rd_chk(12'(ssx_pkg::ADDR_MEM_BASE + 4 * a), mem_m[a]);
   endtask : run

   task automatic preset(input int a, input int av, input int fv, input int mv);
      wr(ssx_pkg::ADDR_ACC, av, 1'b0);
      wr(ssx_pkg::ADDR_FLAGS, fv, 1'b0);
      wr(12'(ssx_pkg::ADDR_MEM_BASE + 4 * a), mv, 1'b0);
      acc_m = av;
      flags_m = fv;
      mem_m[a] = mv;
   endtask : preset

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int op;
      int n;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      num_errors = 0;
      cmp_count = 0;
      seed = 32'h45C9263D;
      acc_m = 0;
      flags_m = 0;
      foreach (mem_m[i]) mem_m[i] = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state of outputs and registers
      chk({30'h0, exec_busy, skip_taken}, 32'h0);
      rd_chk(ssx_pkg::ADDR_ACC, 32'h0);
      rd_chk(ssx_pkg::ADDR_FLAGS, 32'h0);
      rd_chk(ssx_pkg::ADDR_STATUS, 32'h0);
      rd_chk(ssx_pkg::ADDR_MEM_BASE, 32'h0);
      // First pass uses corner operands, later passes random ones
      for (int i = 0; i < 40; i++) begin
         op = i % 8;
         seed = lfsr_next(seed);
         preset(seed[3:0], (i < 8) ? 8'h7F : seed[23:16], seed[29:24],
                (i < 8) ? ((op == 3) ? 0 : 255) : seed[15:8]);
         run(op, seed[6:4], seed[3:0]);
      end
      // A write while busy is refused and leaves the accumulator alone
      preset(3, 8'h11, 0, 8'h40);
      wr(ssx_pkg::ADDR_INSTR, 16'h0303, 1'b0);
      wr(ssx_pkg::ADDR_ACC, 8'h5A, 1'b1);
      n = 0;
      while (exec_busy === 1'b1 && n < 10) begin
         @(posedge pclk);
         n++;
      end
      if (exec_busy === 1'b1) begin
         num_errors++;
         close_out();
      end
      rd_chk(ssx_pkg::ADDR_ACC, 32'h11);
      // Refused places: status is read-only, holes and misalignment
      wr(ssx_pkg::ADDR_STATUS, 8'hFF, 1'b1);
      wr(12'h010, 8'hFF, 1'b1);
      wr(12'h041, 8'hFF, 1'b1);
      close_out();
   end
endmodule : testbench
`default_nettype wire
